// >>> hw/dpd_power_down_control.sv
// Per-channel power-down, reference and gain control of a multi-channel converter
`timescale 1ns/10ps

module dpd_power_down_control (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_valid,
  input wire logic [1:0] wr_channel,
  input wire logic [1:0] wr_power_down_select,
  input wire logic [1:0] wr_reference_select,
  input wire logic wr_gain_select,
  input wire logic [`DPD_CODE_W-1:0] wr_code,
  input wire logic gc_reset,
  input wire logic gc_wakeup,
  input wire logic [2*`DPD_CHANNELS-1:0] nv_power_down_select,
  input wire logic [2*`DPD_CHANNELS-1:0] nv_reference_select,
  input wire logic [`DPD_CHANNELS-1:0] nv_gain_select,
  input wire logic [`DPD_CODE_W*`DPD_CHANNELS-1:0] nv_code,
  input wire logic latch_hold,
  output logic [`DPD_CHANNELS-1:0] amp_enable,
  output logic [`DPD_CHANNELS-1:0] ladder_enable,
  output logic [`DPD_CHANNELS-1:0] ladder_from_ref_pin,
  output logic [`DPD_CHANNELS-1:0] ref_buffer_enable,
  output logic [`DPD_CHANNELS-1:0] bandgap_enable,
  output logic [`DPD_CHANNELS-1:0] pulldown_1k_enable,
  output logic [`DPD_CHANNELS-1:0] pulldown_100k_enable,
  output logic [`DPD_CHANNELS-1:0] gain_two_enable,
  output logic [2*`DPD_CHANNELS-1:0] power_down_select,
  output logic [2*`DPD_CHANNELS-1:0] reference_select,
  output logic [`DPD_CHANNELS-1:0] gain_select,
  output logic [`DPD_CODE_W*`DPD_CHANNELS-1:0] volatile_code,
  output logic [`DPD_CODE_W*`DPD_CHANNELS-1:0] wiper_code,
  output logic [`DPD_CHANNELS-1:0] channel_powered_down,
  output logic nv_program_caution
);

  localparam logic [`DPD_CNT_W-1:0] ENTRY_CYC = `DPD_CNT_W'(`DPD_ENTRY_CYC);
  localparam logic [`DPD_CNT_W-1:0] EXIT_CYC = `DPD_CNT_W'(`DPD_EXIT_CYC);

  dpd_pkg::dpd_state_s state_reg;
  dpd_pkg::dpd_state_s state_next;

  // Supply enables for one channel from its stage and its power-down, reference and gain selection
  function automatic dpd_pkg::dpd_enables_s supply_decode(
    input dpd_pkg::dpd_stage_e stage,
    input logic [1:0] pd_sel,
    input logic [1:0] ref_sel,
    input logic gain
  );
    dpd_pkg::dpd_enables_s e;
    logic running;
    e = '0;
    // Entering still drives until the delay ends; exiting powers circuits first
    running = (stage != dpd_pkg::DPD_DOWN);
    e.amp_on = (stage == dpd_pkg::DPD_DRIVE) || (stage == dpd_pkg::DPD_ENTERING);
    e.ladder_on = running;
    e.ladder_from_pin = running && (ref_sel == `DPD_REF_PIN_UNBUF);
    e.ref_buffer_on = running && ((ref_sel == `DPD_REF_BANDGAP) ||
                                  (ref_sel == `DPD_REF_PIN_BUF));
    // Band gap stays alive in every power-down mode when the reference select is 01, so that wake-up is quick
    e.bandgap_on = (ref_sel == `DPD_REF_BANDGAP);
    e.pulldown_1k = (stage == dpd_pkg::DPD_DOWN) && (pd_sel == `DPD_PD_1K);
    e.pulldown_100k = (stage == dpd_pkg::DPD_DOWN) && (pd_sel == `DPD_PD_100K);
    e.gain_two = gain && (ref_sel != `DPD_REF_SUPPLY);
    return e;
  endfunction : supply_decode

  // Stage sequencing with entry and exit delay counters
  function automatic dpd_pkg::dpd_chan_s stage_step(
    input dpd_pkg::dpd_chan_s c
  );
    dpd_pkg::dpd_chan_s n;
    logic powered_down_sel;
    n = c;
    powered_down_sel = (c.power_down_select != `DPD_PD_NORMAL);
    case (c.stage)
      dpd_pkg::DPD_DRIVE: begin
        if (powered_down_sel) begin
          n.stage = dpd_pkg::DPD_ENTERING;
          n.delay_cnt = ENTRY_CYC - `DPD_CNT_W'(1);
        end
      end
      dpd_pkg::DPD_ENTERING: begin
        if (!powered_down_sel) begin
          // Aborted entry: the amplifier never stopped, so no exit delay is owed
          n.stage = dpd_pkg::DPD_DRIVE;
          n.delay_cnt = '0;
        end else if (c.delay_cnt == '0) begin
          n.stage = dpd_pkg::DPD_DOWN;
        end else begin
          n.delay_cnt = c.delay_cnt - `DPD_CNT_W'(1);
        end
      end
      dpd_pkg::DPD_DOWN: begin
        if (!powered_down_sel) begin
          n.stage = dpd_pkg::DPD_EXITING;
          n.delay_cnt = EXIT_CYC - `DPD_CNT_W'(1);
        end
      end
      dpd_pkg::DPD_EXITING: begin
        if (powered_down_sel) begin
          // The amplifier is still off, so the new mode takes effect at once
          n.stage = dpd_pkg::DPD_DOWN;
          n.delay_cnt = '0;
        end else if (c.delay_cnt == '0) begin
          n.stage = dpd_pkg::DPD_DRIVE;
        end else begin
          n.delay_cnt = c.delay_cnt - `DPD_CNT_W'(1);
        end
      end
      default: begin
        n.stage = dpd_pkg::DPD_DOWN;
        n.delay_cnt = '0;
      end
    endcase
    return n;
  endfunction : stage_step

  always_comb begin
    state_next = state_reg;

    // Latch pin is asynchronous to the command logic
    state_next.latch_meta = latch_hold;
    state_next.latch_sync = state_reg.latch_meta;

    for (int i = 0; i < `DPD_CHANNELS; i++) begin
      // Command updates; besides power-on reset, these are the only ways the selection moves
      if (gc_reset) begin
        state_next.ch[i].power_down_select = nv_power_down_select[2*i +: 2];
        state_next.ch[i].reference_select = nv_reference_select[2*i +: 2];
        state_next.ch[i].gain_select = nv_gain_select[i];
        state_next.ch[i].code = nv_code[`DPD_CODE_W*i +: `DPD_CODE_W];
      end else if (gc_wakeup) begin
        state_next.ch[i].power_down_select = `DPD_PD_NORMAL;
        state_next.ch[i].code = nv_code[`DPD_CODE_W*i +: `DPD_CODE_W];
      end else if (wr_valid && (wr_channel == 2'(i))) begin
        // Accepted in every stage; power-down never blocks commands
        state_next.ch[i].power_down_select = wr_power_down_select;
        state_next.ch[i].reference_select = wr_reference_select;
        state_next.ch[i].gain_select = wr_gain_select;
        state_next.ch[i].code = wr_code;
      end

      // Wiper follows the registered code only while the latch is released
      if (!state_reg.latch_sync) begin
        state_next.ch[i].wiper = state_reg.ch[i].code;
      end

      state_next.ch[i].stage = stage_step(state_reg.ch[i]).stage;
      state_next.ch[i].delay_cnt = stage_step(state_reg.ch[i]).delay_cnt;

      // Enables come from the registered selection and the new stage
      state_next.ch[i].en = supply_decode(state_next.ch[i].stage,
                                          state_reg.ch[i].power_down_select,
                                          state_reg.ch[i].reference_select,
                                          state_reg.ch[i].gain_select);
    end

    // Advisory only: the device does not block programming itself
    state_next.nv_caution =
      (state_reg.ch[0].power_down_select != `DPD_PD_NORMAL) &&
      (state_reg.ch[1].power_down_select != `DPD_PD_NORMAL);

    // Power-on takes the stored selection; outputs stay quiet until stages settle
    if (srst) begin
      state_next = '0;
      for (int i = 0; i < `DPD_CHANNELS; i++) begin
        state_next.ch[i].power_down_select = nv_power_down_select[2*i +: 2];
        state_next.ch[i].reference_select = nv_reference_select[2*i +: 2];
        state_next.ch[i].gain_select = nv_gain_select[i];
        state_next.ch[i].code = nv_code[`DPD_CODE_W*i +: `DPD_CODE_W];
        state_next.ch[i].wiper = nv_code[`DPD_CODE_W*i +: `DPD_CODE_W];
        // Start powered down so a normal selection sees the full exit delay
        state_next.ch[i].stage = dpd_pkg::DPD_DOWN;
        // Band gap stays up through power-on when it is the chosen reference
        state_next.ch[i].en.bandgap_on =
          (nv_reference_select[2*i +: 2] == `DPD_REF_BANDGAP);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  always_comb begin
    for (int i = 0; i < `DPD_CHANNELS; i++) begin
      amp_enable[i] = state_reg.ch[i].en.amp_on;
      ladder_enable[i] = state_reg.ch[i].en.ladder_on;
      ladder_from_ref_pin[i] = state_reg.ch[i].en.ladder_from_pin;
      ref_buffer_enable[i] = state_reg.ch[i].en.ref_buffer_on;
      bandgap_enable[i] = state_reg.ch[i].en.bandgap_on;
      pulldown_1k_enable[i] = state_reg.ch[i].en.pulldown_1k;
      pulldown_100k_enable[i] = state_reg.ch[i].en.pulldown_100k;
      gain_two_enable[i] = state_reg.ch[i].en.gain_two;
      power_down_select[2*i +: 2] = state_reg.ch[i].power_down_select;
      reference_select[2*i +: 2] = state_reg.ch[i].reference_select;
      gain_select[i] = state_reg.ch[i].gain_select;
      volatile_code[`DPD_CODE_W*i +: `DPD_CODE_W] = state_reg.ch[i].code;
      wiper_code[`DPD_CODE_W*i +: `DPD_CODE_W] = state_reg.ch[i].wiper;
      channel_powered_down[i] = (state_reg.ch[i].stage == dpd_pkg::DPD_DOWN);
    end
    nv_program_caution = state_reg.nv_caution;
  end

endmodule : dpd_power_down_control

// >>> hw/dpd_map.svh
// Constants for the converter power-down control block
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH

`define DPD_CHANNELS 4
`define DPD_CODE_W 10
`define DPD_CNT_W 10

`define DPD_PD_NORMAL 2'h0
`define DPD_PD_1K 2'h1
`define DPD_PD_100K 2'h2
`define DPD_PD_OPEN 2'h3

`define DPD_REF_SUPPLY 2'h0
`define DPD_REF_BANDGAP 2'h1
`define DPD_REF_PIN_UNBUF 2'h2
`define DPD_REF_PIN_BUF 2'h3

`define DPD_CLK_PERIOD_NS 10
`define DPD_ENTRY_DELAY_NS 2000
`define DPD_EXIT_DELAY_NS 10000
`define DPD_ENTRY_CYC ((`DPD_ENTRY_DELAY_NS + `DPD_CLK_PERIOD_NS - 1) / `DPD_CLK_PERIOD_NS)
`define DPD_EXIT_CYC ((`DPD_EXIT_DELAY_NS + `DPD_CLK_PERIOD_NS - 1) / `DPD_CLK_PERIOD_NS)

`endif

// >>> hw/dpd_pkg.sv
// Types for the converter power-down control block
`include "dpd_map.svh"

package dpd_pkg;

  typedef enum logic [1:0] {
    DPD_DRIVE = 2'h0,
    DPD_ENTERING = 2'h1,
    DPD_DOWN = 2'h3,
    DPD_EXITING = 2'h2
  } dpd_stage_e;

  typedef struct packed {
    logic amp_on;
    logic ladder_on;
    logic ladder_from_pin;
    logic ref_buffer_on;
    logic bandgap_on;
    logic pulldown_1k;
    logic pulldown_100k;
    logic gain_two;
  } dpd_enables_s;

  typedef struct packed {
    logic [1:0] power_down_select;
    logic [1:0] reference_select;
    logic gain_select;
    logic [`DPD_CODE_W-1:0] code;
    logic [`DPD_CODE_W-1:0] wiper;
    dpd_stage_e stage;
    logic [`DPD_CNT_W-1:0] delay_cnt;
    dpd_enables_s en;
  } dpd_chan_s;

  typedef struct packed {
    logic latch_meta;
    logic latch_sync;
    logic nv_caution;
    dpd_chan_s [`DPD_CHANNELS-1:0] ch;
  } dpd_state_s;

endpackage : dpd_pkg

// >>> tb/dpd_host.sv
// Command source standing in for the two-wire bus host
`timescale 1ns/10ps
module dpd_host (
  input wire logic clk_sys,
  output logic wr_valid,
  output logic [1:0] wr_channel,
  output logic [1:0] wr_power_down_select,
  output logic [1:0] wr_reference_select,
  output logic wr_gain_select,
  output logic [9:0] wr_code,
  output logic gc_reset,
  output logic gc_wakeup
);
  // Never starts nonvolatile programming, so any pair of channels may sleep
  initial begin
    {wr_valid, wr_channel, wr_power_down_select, wr_reference_select} = '0;
    {wr_gain_select, wr_code, gc_reset, gc_wakeup} = '0;
  end
  // Kind is {reset, wake-up, write}; sent in any power-down state
  task automatic cmd(input logic [2:0] kind, input logic [1:0] ch, input logic [1:0] pd,
      input logic [2:0] rg, input logic [9:0] code);
    @(negedge clk_sys);
    {gc_reset, gc_wakeup, wr_valid} = kind;
    {wr_channel, wr_power_down_select, wr_reference_select, wr_gain_select} = {ch, pd, rg};
    wr_code = code;
    @(negedge clk_sys);
    {gc_reset, gc_wakeup, wr_valid} = 3'h0;
    // Stale data is scrambled so a late sample cannot pass by luck
    wr_code = ~code;
  endtask : cmd
endmodule : dpd_host

// >>> tb/dpd_checker_properties.sv
// Timing relations watched on the ports of the power-down control block
`timescale 1ns/10ps
module dpd_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_valid,
  input wire logic [1:0] wr_channel,
  input wire logic [1:0] wr_power_down_select,
  input wire logic [9:0] wr_code,
  input wire logic gc_reset,
  input wire logic gc_wakeup,
  input wire logic latch_hold,
  input wire logic [3:0] amp_enable,
  input wire logic [3:0] ladder_enable,
  input wire logic [3:0] bandgap_enable,
  input wire logic [3:0] pulldown_1k_enable,
  input wire logic [3:0] pulldown_100k_enable,
  input wire logic [3:0] gain_two_enable,
  input wire logic [7:0] power_down_select,
  input wire logic [7:0] reference_select,
  input wire logic [39:0] volatile_code,
  input wire logic [39:0] wiper_code,
  input wire logic [3:0] channel_powered_down
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  write_takes_a: assert property (
    wr_valid && !gc_reset && !gc_wakeup && wr_channel == 2'h0 |=> power_down_select[1:0]
    == $past(wr_power_down_select) && volatile_code[9:0] == $past(wr_code))
    else $error("write not taken");
  wake_clear_a: assert property (
    gc_wakeup |=> power_down_select == 8'h00) else $error("wake-up left a channel down");
  keep_fields_a: assert property (
    !(wr_valid | gc_reset | gc_wakeup) |=> $stable(power_down_select)
    && $stable(reference_select) && $stable(volatile_code))
    else $error("fields moved without a command");
  entry_hold_a: assert property (
    $rose(power_down_select[1:0] != 2'h0) && amp_enable[0] |=> amp_enable[0] [*8])
    else $error("amplifier stopped at once");
  exit_hold_a: assert property (
    $fell(power_down_select[1:0] != 2'h0) && !amp_enable[0] |=> !amp_enable[0] [*8])
    else $error("amplifier drove at once");
  pd_release_a: assert property (
    $fell(power_down_select[1:0] != 2'h0) |-> ##[1:3]
    !(pulldown_1k_enable[0] | pulldown_100k_enable[0])) else $error("load kept");
  amp_off_a: assert property (
    $past(channel_powered_down[0]) && channel_powered_down[0] |->
    !amp_enable[0] && !ladder_enable[0]) else $error("amplifier on while down");
  load_decode_a: assert property (
    ($stable(power_down_select[1:0]) && channel_powered_down[0]) [*3] |->
    {pulldown_1k_enable[0], pulldown_100k_enable[0]} ==
    {power_down_select[1:0] == 2'h1, power_down_select[1:0] == 2'h2})
    else $error("wrong load");
  gain_unity_a: assert property (
    (reference_select[1:0] == 2'h0) [*3] |-> !gain_two_enable[0])
    else $error("gain two on supply");
  bandgap_a: assert property (
    $stable(reference_select[1:0]) [*3] |->
    bandgap_enable[0] == (reference_select[1:0] == 2'h1)) else $error("band gap wrong");
  latch_follow_a: assert property (
    (!latch_hold) [*4] |-> wiper_code == $past(volatile_code))
    else $error("wiper not following");
endmodule : dpd_checker

// >>> tb/tb.sv
// Self-checking bench for the power-down control block
`timescale 1ns/10ps
module tb;
  logic clk_sys = 0, srst = 1, latch_hold = 0;
  logic wr_valid, wr_gain_select, gc_reset, gc_wakeup, nv_program_caution;
  logic [1:0] wr_channel, wr_power_down_select, wr_reference_select;
  logic [9:0] wr_code;
  logic [7:0] nv_power_down_select = 8'h40, nv_reference_select = 8'he4;
  logic [7:0] power_down_select, reference_select;
  logic [3:0] nv_gain_select = 4'hf, amp_enable, ladder_enable, ladder_from_ref_pin;
  logic [3:0] ref_buffer_enable, bandgap_enable, pulldown_1k_enable, pulldown_100k_enable;
  logic [3:0] gain_two_enable, gain_select, channel_powered_down;
  logic [39:0] nv_code = 40'h12_3456_789a, volatile_code, wiper_code;
  int err_count = 0, tests_run = 0, n;
  // {select, reference, gain, amp ladder pin buffer gap 1k 100k gain-two}
  logic [12:0] rows [8] = '{13'h01c0, 13'h03d9, 13'h05e1, 13'h06d0,
    13'h0a0c, 13'h1002, 13'h1c00, 13'h1e00};
  dpd_power_down_control dut (.*);
  dpd_host host (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [39:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] en(int c);
    return {amp_enable[c], ladder_enable[c], ladder_from_ref_pin[c], ref_buffer_enable[c],
      bandgap_enable[c], pulldown_1k_enable[c], pulldown_100k_enable[c], gain_two_enable[c]};
  endfunction : en
  // Bounded wait, so a stuck amplifier shows as 1200
  task automatic span(input int c, input logic lvl);
    n = 0;
    while (amp_enable[c] !== lvl && n < 1200) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : span
  task automatic conclude();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    #200_000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 0;
    for (int i = 0; i < 8; i++) begin
      host.cmd(3'h1, 2'h0, rows[i][12:11], rows[i][10:8], 10'h155);
      repeat (1010) @(negedge clk_sys);
      check("enables", en(0), rows[i][7:0]);
    end
    host.cmd(3'h1, 2'h1, 2'h2, 3'h2, 10'h0aa);
    span(1, 0);
    check("entry delay", n >= 199 && n <= 205, 1);
    check("kept code", volatile_code[19:10], 10'h0aa);
    host.cmd(3'h1, 2'h1, 2'h0, 3'h2, 10'h0aa);
    span(1, 1);
    check("exit delay", n >= 999 && n <= 1005, 1);
    host.cmd(3'h1, 2'h1, 2'h1, 3'h2, 10'h0aa);
    repeat (20) @(negedge clk_sys);
    host.cmd(3'h1, 2'h1, 2'h0, 3'h2, 10'h0aa);
    span(1, 0);
    check("aborted entry", n, 1200);
    host.cmd(3'h1, 2'h1, 2'h3, 3'h2, 10'h0aa);
    repeat (3) @(negedge clk_sys);
    check("caution", nv_program_caution, 1);
    check("other channel", power_down_select[1:0], 2'h3);
    latch_hold = 1;
    repeat (3) @(negedge clk_sys);
    host.cmd(3'h1, 2'h2, 2'h0, 3'h4, 10'h2aa);
    repeat (3) @(negedge clk_sys);
    check("held wiper", wiper_code[29:20], nv_code[29:20]);
    check("held code", volatile_code[29:20], 10'h2aa);
    latch_hold = 0;
    repeat (5) @(negedge clk_sys);
    check("released wiper", wiper_code[29:20], 10'h2aa);
    host.cmd(3'h2, 2'h0, 2'h0, 3'h0, 10'h000);
    repeat (2) @(negedge clk_sys);
    check("wake select", power_down_select, 8'h00);
    check("wake code", volatile_code, nv_code);
    nv_code = 40'h0f_0f0f_0f0f;
    host.cmd(3'h4, 2'h0, 2'h0, 3'h0, 10'h000);
    repeat (2) @(negedge clk_sys);
    check("general reset", {power_down_select, reference_select, volatile_code},
      {nv_power_down_select, nv_reference_select, nv_code});
    nv_power_down_select = 8'h1b;
    srst = 1;
    repeat (4) @(negedge clk_sys);
    check("reset amp", amp_enable, 4'h0);
    srst = 0;
    repeat (3) @(negedge clk_sys);
    check("power-on", {power_down_select, gain_select, wiper_code},
      {nv_power_down_select, nv_gain_select, nv_code});
    conclude();
  end
endmodule : tb
bind dpd_power_down_control dpd_checker chk (.*);
